// file: verilog/ssv_top.sv
// Safe-stop source supervisor: attributes stops, keeps alarm words.
// Assumes pins synchronous to i_mclk and an APB master on the bus.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Low safe-stop input, high card input active.
// - Card input decides which source stopped.
// - Selection 4: card stop coasts, latched alarm.
// - Selection 5: card stop gives warning, autorestart.
// - Selection 6: relay stop attributed separately.
// - Selection 7: both sources warn, autorestart.
// - Selections 8, 9 mix alarm and warning.
// - Selections 4-9 only with card fitted.
// - Trips of 68, 71 need manual reset; 72 clears only on system reset.
// - Events 68, 71 on bit 30.
// - Dangerous failure on secondary alarm bit 31.
// - Relay alarm clears after restore, then reset.
// - Relay warning clears when stop releases.
// - Card alarm clears after both release, reset.
// - Card warning clears when both inputs release.
// - Card active without stop gives failure alarm.
// - Selections 4, 5: stop without card fails.
// - Selections 0, 1, 3 ignore the card input.
module ssv_top (
	input  wire logic                       i_mclk,
	input  wire logic                       i_rst,
	input  wire logic                       i_safe_stop_n,
	input  wire logic                       i_card_status,
	input  wire logic                       i_card_fitted,
	input  wire logic                       i_reset_req,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [ssv_pkg::ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]                i_pwdata,
	output logic [31:0]                     o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	output logic                            o_coast
);
	import ssv_pkg::*;

	// ****************************************************************
	// Selection decoding
	// ****************************************************************

	function automatic logic card_aware(input logic [3:0] sel);
		card_aware = (sel >= SEL_CARD_A) && (sel <= SEL_CW_RA);
	endfunction

	// Card-aware selections are accepted only while the card is fitted.
	function automatic logic sel_allowed(input logic [3:0] sel,
		input logic fitted);
		sel_allowed = (sel == SEL_NONE) || (sel == SEL_RLY_A) ||
			(sel == SEL_RLY_W) || (fitted && card_aware(sel));
	endfunction

	// Alarm rather than warning for a card-initiated stop.
	function automatic logic card_is_alarm(input logic [3:0] sel);
		card_is_alarm = (sel == SEL_CARD_A) || (sel == SEL_BOTH_A) ||
			(sel == SEL_CA_RW);
	endfunction

	// Alarm rather than warning for a relay-initiated stop.
	function automatic logic relay_is_alarm(input logic [3:0] sel);
		relay_is_alarm = (sel == SEL_RLY_A) || (sel == SEL_BOTH_A) ||
			(sel == SEL_CW_RA);
	endfunction

	function automatic logic relay_shared(input logic [3:0] sel);
		relay_shared = (sel >= SEL_BOTH_A) && (sel <= SEL_CW_RA);
	endfunction

	function automatic logic [31:0] bit_word(input logic b, input int pos);
		bit_word = '0;
		bit_word[pos] = b;
	endfunction

	// ****************************************************************
	// State and input interpretation
	// ****************************************************************

	ssv_top_s st;
	ssv_top_s next_st;

	ssv_evt_if relay_evt ();
	ssv_evt_if card_evt ();

	logic ss_act;
	logic card_raw;
	logic card_req;
	logic aware;
	logic any_reset;
	logic df_trip;
	logic access;
	logic [31:0] alarm1;
	logic [31:0] alarm2;
	logic [31:0] warn1;
	logic [31:0] warn2;
	logic [31:0] stat;
	logic [31:0] rd_word;
	logic rd_hit;

	assign ss_act   = !i_safe_stop_n;
	assign card_raw = i_card_status;
	assign aware    = card_aware(st.sel);
	// The card input counts only in card-aware selections; the
	// safe-stop pin still stops the drive in every selection.
	assign card_req = aware && card_raw;
	assign any_reset = i_reset_req || st.rst_cmd;

	// Dangerous-failure combinations of the two inputs.
	assign df_trip = (card_req && !ss_act) ||
		(ss_act && !card_raw && ((st.sel == SEL_CARD_A) ||
		(st.sel == SEL_CARD_W)));

	// ****************************************************************
	// Source attribution and event latches
	// ****************************************************************

	// The card input names the source, since other devices may pull
	// the same safe-stop pin at the same time.
	always_comb begin
		card_evt.activate  = ss_act && card_req;
		card_evt.as_alarm  = card_is_alarm(st.sel);
		card_evt.clear_ok  = !ss_act && !card_raw;
		card_evt.reset_req = any_reset;
		relay_evt.activate = 1'b0;
		if (relay_shared(st.sel)) begin
			relay_evt.activate = ss_act && !card_raw;
		end else if (!aware && (st.sel != SEL_NONE)) begin
			relay_evt.activate = ss_act;
		end
		relay_evt.as_alarm  = relay_is_alarm(st.sel);
		relay_evt.clear_ok  = !ss_act;
		relay_evt.reset_req = any_reset;
	end

	ssv_latch u_relay (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.evt    (relay_evt.lat)
	);

	ssv_latch u_card (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.evt    (card_evt.lat)
	);

	// ****************************************************************
	// Status words
	// ****************************************************************

	assign alarm1 = bit_word(relay_evt.alarm, EVT_BIT);
	assign alarm2 = bit_word(card_evt.alarm, EVT_BIT) |
		bit_word(st.df_alarm, DF_BIT);
	assign warn1  = bit_word(relay_evt.warning, EVT_BIT);
	assign warn2  = bit_word(card_evt.warning, EVT_BIT);
	assign stat   = bit_word(ss_act, ST_SS_BIT) |
		bit_word(card_raw, ST_CARD_BIT) |
		bit_word(i_card_fitted, ST_FIT_BIT) |
		bit_word(st.coast, ST_COAST_BIT);

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = '0;
		case (i_paddr)
			OFS_ALARM1: rd_word = alarm1;
			OFS_ALARM2: rd_word = alarm2;
			OFS_WARN1:  rd_word = warn1;
			OFS_WARN2:  rd_word = warn2;
			OFS_CTRL:   rd_word = {28'h0000000, st.sel};
			OFS_CMD:    rd_word = '0;
			OFS_STAT:   rd_word = stat;
			default:    rd_hit = 1'b0;
		endcase
	end

	// ****************************************************************
	// Next state: APB slave, failure trip, coast
	// ****************************************************************

	// Each access phase lasts two cycles: pready rises one edge after
	// penable, and the write or read acts on that same decision.
	assign access = i_psel && i_penable && !st.pready;

	always_comb begin
		next_st         = st;
		next_st.pready  = access;
		next_st.pslverr = 1'b0;
		next_st.rst_cmd = 1'b0;
		if (access) begin
			next_st.prdata  = i_pwrite ? 32'h00000000 : rd_word;
			next_st.pslverr = !rd_hit;
			if (i_pwrite && (i_paddr == OFS_CTRL) &&
				sel_allowed(i_pwdata[SEL_W-1:0], i_card_fitted)) begin
				next_st.sel = i_pwdata[SEL_W-1:0];
			end
			if (i_pwrite && (i_paddr == OFS_CMD)) begin
				next_st.rst_cmd = i_pwdata[CMD_RST_BIT];
			end
		end
		// Trip lock: no ordinary reset path touches this bit.
		if (df_trip) begin
			next_st.df_alarm = 1'b1;
		end
		next_st.coast = ss_act || next_st.df_alarm ||
			card_evt.alarm || card_evt.warning ||
			relay_evt.alarm || relay_evt.warning;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st     <= '0;
			st.sel <= SEL_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign o_prdata  = st.prdata;
	assign o_pready  = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_coast   = st.coast;

	// ****************************************************************
	// Checks
	// ****************************************************************

	sequence s_card_stop;
		ss_act && card_raw && card_is_alarm(st.sel);
	endsequence

	sequence s_card_alarm_seen;
		alarm2[EVT_BIT] && o_coast;
	endsequence

	property p_card_trip;
		@(posedge i_mclk) disable iff (i_rst)
		s_card_stop |=> s_card_alarm_seen;
	endproperty

	chk_card_alarm_word: assert property (p_card_trip)
		else $error("card stop did not raise card alarm");

	chk_df_card_only: assert property (@(posedge i_mclk)
		disable iff (i_rst) aware && card_raw && !ss_act
		|=> st.df_alarm && alarm2[DF_BIT])
		else $error("card without stop missed failure alarm");

	chk_df_stop_only: assert property (@(posedge i_mclk)
		disable iff (i_rst) ss_act && !card_raw &&
		((st.sel == SEL_CARD_A) || (st.sel == SEL_CARD_W))
		|=> st.df_alarm)
		else $error("stop without card missed failure alarm");

	chk_df_locked: assert property (@(posedge i_mclk)
		disable iff (i_rst) st.df_alarm |=> st.df_alarm [*2])
		else $error("failure alarm dropped before system reset");

	chk_stop_coasts: assert property (@(posedge i_mclk)
		disable iff (i_rst) ss_act |=> o_coast)
		else $error("active safe stop did not coast");

	chk_sel_hidden: assert property (@(posedge i_mclk)
		disable iff (i_rst) !i_card_fitted && !card_aware(st.sel)
		|=> !card_aware(st.sel))
		else $error("card selection accepted without card");

	chk_card_ignored: assert property (@(posedge i_mclk)
		disable iff (i_rst) !aware && card_raw &&
		!st.df_alarm && !ss_act |=> !st.df_alarm)
		else $error("card input not ignored");

	chk_relay_warn: assert property (@(posedge i_mclk)
		disable iff (i_rst) (st.sel == SEL_RLY_W) && ss_act
		|=> warn1[EVT_BIT] && !alarm1[EVT_BIT])
		else $error("relay warning missing");

	chk_apb_ready: assert property (@(posedge i_mclk)
		disable iff (i_rst) i_psel && i_penable && !o_pready
		|=> o_pready ##1 !o_pready)
		else $error("pready not a single cycle answer");

	// ****************************************************************
	// Checks on attribution and clearing
	// ****************************************************************

	sequence s_card_warn_stop;
		ss_act && card_req && !card_is_alarm(st.sel);
	endsequence

	sequence s_card_warn_seen;
		warn2[EVT_BIT] && o_coast;
	endsequence

	sequence s_relay_shared_stop;
		relay_shared(st.sel) && ss_act && !card_raw;
	endsequence

	sequence s_relay_event_seen;
		alarm1[EVT_BIT] || warn1[EVT_BIT];
	endsequence

	chk_card_warn_word: assert property (@(posedge i_mclk)
		disable iff (i_rst) s_card_warn_stop |=> s_card_warn_seen)
		else $error("card stop did not raise card warning");

	chk_relay_source: assert property (@(posedge i_mclk)
		disable iff (i_rst) s_relay_shared_stop |=> s_relay_event_seen)
		else $error("relay stop not attributed to relay");

	chk_card_not_relay: assert property (@(posedge i_mclk)
		disable iff (i_rst) relay_shared(st.sel) && ss_act &&
		card_raw && !relay_evt.alarm && !relay_evt.warning
		|=> !alarm1[EVT_BIT] && !warn1[EVT_BIT])
		else $error("card stop blamed on relay");

	chk_card_alarm_kept: assert property (@(posedge i_mclk)
		disable iff (i_rst) card_evt.alarm && (ss_act || card_raw)
		|=> alarm2[EVT_BIT])
		else $error("card alarm cleared while inputs active");

	chk_card_warn_clear: assert property (@(posedge i_mclk)
		disable iff (i_rst) card_evt.warning && !ss_act && !card_raw
		|=> !warn2[EVT_BIT])
		else $error("card warning did not clear");

	chk_relay_reset: assert property (@(posedge i_mclk)
		disable iff (i_rst) relay_evt.alarm && !ss_act && any_reset
		|=> !alarm1[EVT_BIT])
		else $error("relay alarm survived a valid reset");

	chk_relay_kept: assert property (@(posedge i_mclk)
		disable iff (i_rst) relay_evt.alarm && ss_act |=> alarm1[EVT_BIT])
		else $error("relay alarm cleared while stop active");
endmodule
`default_nettype wire

// file: verilog/ssv_pkg.sv
// Constants and types for the safe-stop source supervisor.
// Assumes a 32-bit APB register bus and one control clock.
package ssv_pkg;
	localparam int          SEL_W        = 4;
	localparam int          ADDR_W       = 8;
	localparam int          EVT_BIT      = 30;
	localparam int          DF_BIT       = 31;
	localparam int          CMD_RST_BIT  = 0;
	localparam int          ST_SS_BIT    = 0;
	localparam int          ST_CARD_BIT  = 1;
	localparam int          ST_FIT_BIT   = 2;
	localparam int          ST_COAST_BIT = 3;
	localparam logic [7:0]  OFS_ALARM1   = 8'h00;
	localparam logic [7:0]  OFS_ALARM2   = 8'h04;
	localparam logic [7:0]  OFS_WARN1    = 8'h08;
	localparam logic [7:0]  OFS_WARN2    = 8'h0C;
	localparam logic [7:0]  OFS_CTRL     = 8'h10;
	localparam logic [7:0]  OFS_CMD      = 8'h14;
	localparam logic [7:0]  OFS_STAT     = 8'h18;
	localparam logic [3:0]  SEL_NONE     = 4'h0;
	localparam logic [3:0]  SEL_RLY_A    = 4'h1;
	localparam logic [3:0]  SEL_RLY_W    = 4'h3;
	localparam logic [3:0]  SEL_CARD_A   = 4'h4;
	localparam logic [3:0]  SEL_CARD_W   = 4'h5;
	localparam logic [3:0]  SEL_BOTH_A   = 4'h6;
	localparam logic [3:0]  SEL_BOTH_W   = 4'h7;
	localparam logic [3:0]  SEL_CA_RW    = 4'h8;
	localparam logic [3:0]  SEL_CW_RA    = 4'h9;
	localparam logic [3:0]  SEL_RESET    = SEL_RLY_A;

	typedef struct packed {
		logic alarm;
		logic warning;
	} ssv_evt_s;

	typedef struct packed {
		logic [3:0]  sel;
		logic        df_alarm;
		logic        rst_cmd;
		logic        coast;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ssv_top_s;
endpackage

// file: verilog/ssv_evt_if.sv
// Carrier between the supervisor and one stop-source event latch.
// Assumes both ends run on the same control clock.
`timescale 1ns/10ps
`default_nettype none
interface ssv_evt_if;
	logic activate;
	logic as_alarm;
	logic clear_ok;
	logic reset_req;
	logic alarm;
	logic warning;

	modport ctl (output activate, as_alarm, clear_ok, reset_req,
		input alarm, warning);
	modport lat (input activate, as_alarm, clear_ok, reset_req,
		output alarm, warning);
endinterface
`default_nettype wire

// file: verilog/ssv_latch.sv
// Alarm or warning latch for one safe-stop source.
// Assumes activate and clear_ok are mutually exclusive conditions.
`timescale 1ns/10ps
`default_nettype none
module ssv_latch (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	ssv_evt_if.lat    evt
);
	import ssv_pkg::*;

	ssv_evt_s st;
	ssv_evt_s next_st;

	// A trip only leaves with a manual reset once inputs are healthy;
	// a new activation in the same cycle keeps it set.
	always_comb begin
		next_st = st;
		if (evt.activate && evt.as_alarm) begin
			next_st.alarm = 1'b1;
		end else if (evt.reset_req && evt.clear_ok) begin
			next_st.alarm = 1'b0;
		end
		if (evt.activate && !evt.as_alarm) begin
			next_st.warning = 1'b1;
		end else if (evt.clear_ok) begin
			next_st.warning = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign evt.alarm   = st.alarm;
	assign evt.warning = st.warning;

	chk_alarm_held: assert property (@(posedge i_mclk) disable iff (i_rst)
		st.alarm && !(evt.reset_req && evt.clear_ok) |=> st.alarm)
		else $error("alarm dropped without a valid reset");
	chk_warn_autoclear: assert property (@(posedge i_mclk) disable iff (i_rst)
		st.warning && evt.clear_ok && !evt.activate |=> !st.warning)
		else $error("warning did not clear automatically");
endmodule
`default_nettype wire

// file: tb/ssv_card_model.sv
// Model of the thermistor card and an emergency-stop relay chain.
// Assumes the bench sets its commands right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module ssv_card_model (
	input  wire logic i_mclk,
	input  wire logic i_card_hot,
	input  wire logic i_estop,
	input  wire logic i_card_only,
	output logic      o_safe_stop_n,
	output logic      o_card_status
);
	initial begin
		o_safe_stop_n = 1'b1;
		o_card_status = 1'b0;
	end
	// The shared stop line is pulled low by either source.
	always @(posedge i_mclk) begin
		o_safe_stop_n <= !(i_card_hot | i_estop);
		o_card_status <= i_card_hot | i_card_only;
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench for the safe-stop source supervisor; APB answers go via a queue.
// Assumes the card model on the stop pins and one 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ssv_pkg::*;
	localparam logic [31:0] EVT = 32'h1 << EVT_BIT;
	localparam logic [31:0] DFB = 32'h1 << DF_BIT;
	logic        i_mclk, i_rst, i_fitted, i_rreq, i_psel, i_penable;
	logic        i_pwrite, o_pready, o_pslverr, o_coast, ss_n, card;
	logic        card_hot, estop, card_only, ca, ra;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata;
	logic [41:0] notes[$];
	logic [41:0] n;
	int          fails, checks;

	ssv_top DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_safe_stop_n(ss_n),
		.i_card_status(card), .i_card_fitted(i_fitted),
		.i_reset_req(i_rreq), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_coast(o_coast));
	ssv_card_model card_model (.i_mclk(i_mclk), .i_card_hot(card_hot),
		.i_estop(estop), .i_card_only(card_only),
		.o_safe_stop_n(ss_n), .o_card_status(card));

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	task automatic check(input string name, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out;
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Each answer is compared with the oldest note taken at request time.
	always @(posedge i_mclk) begin
		if (o_pready === 1'b1) begin
			n = notes.pop_front();
			check($sformatf("error at %h", n[41:34]), {31'h0, o_pslverr},
				{31'h0, n[32]});
			if (n[33])
				check($sformatf("word at %h", n[41:34]), o_prdata, n[31:0]);
		end
	end

	// ****************************************************************
	// Bus and pin tasks
	// ****************************************************************
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [33:0] exp);
		notes.push_back({a, exp});
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_mclk);
		end while (o_pready !== 1'b1);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {2'b10, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {2'b00, 32'h0});
	endtask

	task automatic words(input logic [31:0] p1, s1, pw, sw);
		rd(OFS_ALARM1, p1);
		rd(OFS_ALARM2, s1);
		rd(OFS_WARN1, pw);
		rd(OFS_WARN2, sw);
	endtask

	task automatic stim(input logic c, e, f);
		@(posedge i_mclk);
		card_hot <= c;
		estop <= e;
		card_only <= f;
		repeat (4) @(posedge i_mclk);
	endtask

	// The manual reset comes either from the pin or from the command word.
	task automatic clr;
		if ($urandom % 2) begin
			wr(OFS_CMD, 32'h1);
		end else begin
			@(posedge i_mclk);
			i_rreq <= 1'b1;
			@(posedge i_mclk);
			i_rreq <= 1'b0;
		end
		repeat (3) @(posedge i_mclk);
	endtask

	task automatic sys_reset;
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
	endtask

	initial begin
		#400000;
		fails++;
		close_out();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'hDF043B15));
		fails = 0;
		checks = 0;
		{i_rst, i_fitted, i_rreq, i_psel, i_penable, i_pwrite} = 6'h20;
		{card_hot, estop, card_only} = 3'h0;
		i_paddr = 8'h0;
		i_pwdata = 32'h0;
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		words(32'h0, 32'h0, 32'h0, 32'h0);
		rd(OFS_CTRL, {28'h0, SEL_RESET});
		apb(1'b1, 8'h1C, $urandom, {2'b01, 32'h0});
		apb(1'b0, 8'h1C, 32'h0, {2'b11, 32'h0});
		wr(OFS_ALARM2, $urandom);
		rd(OFS_ALARM2, 32'h0);
		stim(1'b1, 1'b0, 1'b0);
		words(EVT, 32'h0, 32'h0, 32'h0);
		rd(OFS_STAT, 32'hB);
		clr();
		rd(OFS_ALARM1, EVT);
		stim(1'b0, 1'b0, 1'b0);
		rd(OFS_STAT, 32'h8);
		clr();
		words(32'h0, 32'h0, 32'h0, 32'h0);
		wr(OFS_CTRL, 32'h3);
		stim(1'b0, 1'b1, 1'b0);
		words(32'h0, 32'h0, EVT, 32'h0);
		stim(1'b0, 1'b0, 1'b0);
		words(32'h0, 32'h0, 32'h0, 32'h0);
		stim(1'b0, 1'b0, 1'b1);
		words(32'h0, 32'h0, 32'h0, 32'h0);
		rd(OFS_STAT, 32'h2);
		stim(1'b0, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h4);
		rd(OFS_CTRL, 32'h3);
		@(posedge i_mclk);
		i_fitted <= 1'b1;
		wr(OFS_CTRL, 32'h4);
		rd(OFS_CTRL, 32'h4);
		stim(1'b1, 1'b0, 1'b0);
		words(32'h0, EVT, 32'h0, 32'h0);
		rd(OFS_STAT, 32'hF);
		check("coast", {31'h0, o_coast}, 32'h1);
		clr();
		rd(OFS_ALARM2, EVT);
		stim(1'b0, 1'b0, 1'b0);
		rd(OFS_STAT, 32'hC);
		clr();
		words(32'h0, 32'h0, 32'h0, 32'h0);
		rd(OFS_STAT, 32'h4);
		wr(OFS_CTRL, 32'h5);
		stim(1'b1, 1'b0, 1'b0);
		words(32'h0, 32'h0, 32'h0, EVT);
		stim(1'b0, 1'b0, 1'b0);
		words(32'h0, 32'h0, 32'h0, 32'h0);
		check("coast", {31'h0, o_coast}, 32'h0);
		for (int s = 6; s <= 9; s++) begin
			wr(OFS_CTRL, 32'(s));
			ca = (s == 6 || s == 8);
			ra = (s == 6 || s == 9);
			stim(1'b1, 1'b0, 1'b0);
			words(32'h0, ca ? EVT : 32'h0, 32'h0, ca ? 32'h0 : EVT);
			stim(1'b0, 1'b0, 1'b0);
			clr();
			stim(1'b0, 1'b1, 1'b0);
			words(ra ? EVT : 32'h0, 32'h0, ra ? 32'h0 : EVT, 32'h0);
			stim(1'b0, 1'b0, 1'b0);
			clr();
			words(32'h0, 32'h0, 32'h0, 32'h0);
		end
		wr(OFS_CTRL, 32'h6);
		stim(1'b0, 1'b0, 1'b1);
		words(32'h0, DFB, 32'h0, 32'h0);
		stim(1'b0, 1'b0, 1'b0);
		clr();
		rd(OFS_ALARM2, DFB);
		sys_reset();
		wr(OFS_CTRL, 32'h4);
		stim(1'b0, 1'b1, 1'b0);
		words(32'h0, DFB, 32'h0, 32'h0);
		stim(1'b0, 1'b0, 1'b0);
		sys_reset();
		words(32'h0, 32'h0, 32'h0, 32'h0);
		repeat (3) @(posedge i_mclk);
		close_out();
	end
endmodule
`default_nettype wire
